// ==== logic/pof_pkg.sv ====
/*
  Shared constants and carrier types for the pixel output formatter.
  Assumes a single 100 MHz clock domain and a synchronous active-low reset.
*/
`default_nettype none
package pof_pkg;
  // coding selector identifiers
  localparam logic [7:0] POF_CODE_Y8   = 8'h00;
  localparam logic [7:0] POF_CODE_P12  = 8'h86;
  localparam logic [7:0] POF_CODE_G16  = 8'h05;
  localparam int         POF_SEL_W     = 8;
  localparam int         POF_PIX_W     = 12;
  localparam int         POF_BYTE_W    = 8;
  localparam int         POF_CHAN_W    = 8;
  // luma weights, scaled by 256 (77/150/29 sum to 256)
  localparam logic [7:0] POF_KR        = 8'h4d;
  localparam logic [7:0] POF_KG        = 8'h96;
  localparam logic [7:0] POF_KB        = 8'h1d;
  localparam int         POF_LUMA_SH   = 8;
  // field positions of a 12-bit pixel
  localparam int         POF_HI_MSB    = 11;
  localparam int         POF_HI_LSB    = 4;
  localparam int         POF_LO_MSB    = 3;
  localparam logic [3:0] POF_PAD_ZERO  = 4'h0;
  localparam logic [7:0] POF_BYTE_RST  = 8'h00;

  typedef struct packed {
    logic                  sof;
    logic [POF_CHAN_W-1:0] r;
    logic [POF_CHAN_W-1:0] g;
    logic [POF_CHAN_W-1:0] b;
    logic [POF_PIX_W-1:0]  grey;
  } pof_pix_s;

  typedef struct packed {
    logic                  sof;
    logic [POF_BYTE_W-1:0] data;
  } pof_byte_s;

  typedef enum logic [1:0] {
    POF_ST_IDLE = 2'b00,
    POF_ST_B1   = 2'b01,
    POF_ST_B2   = 2'b10
  } pof_state_e;
endpackage
`default_nettype wire

// ==== logic/pof_luma.sv ====
/*
  Luminance from interpolated RGB channels, registered one cycle.
  Assumes channels are already demosaiced upstream.
*/
`timescale 1ns/1ps
`default_nettype none
module pof_luma
  import pof_pkg::*;
#(
  parameter int CHAN_W = POF_CHAN_W
) (
  input  wire logic              mclk_i,
  input  wire logic              nrst_i,
  input  wire logic              ce_i,
  input  wire logic [CHAN_W-1:0] r_i,
  input  wire logic [CHAN_W-1:0] g_i,
  input  wire logic [CHAN_W-1:0] b_i,
  output logic      [CHAN_W-1:0] y_o
);
  logic [CHAN_W+9:0] sum;
  logic [CHAN_W-1:0] next_y;
  logic [CHAN_W-1:0] y;

  always_comb begin
    sum = (CHAN_W+10)'(r_i * POF_KR) + (CHAN_W+10)'(g_i * POF_KG) + (CHAN_W+10)'(b_i * POF_KB);
    // weights sum to 256, so the quotient never exceeds the channel range
    next_y = sum[POF_LUMA_SH +: CHAN_W];
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      y <= '0;
    end else if (ce_i) begin
      y <= next_y;
    end
  end

  assign y_o = y;
endmodule
`default_nettype wire

// ==== logic/pof_formatter.sv ====
/*
  Pixel output formatter: turns a pixel stream into host bytes in one of
  three codings picked by output_coding_selector_i.
  Assumes the downstream byte sink accepts one byte per enabled cycle and
  that a new pixel is offered only while pix_ready_o is high.
*/
`timescale 1ns/1ps
`default_nettype none
module pof_formatter
  import pof_pkg::*;
(
  input  wire logic                 mclk_i,
  input  wire logic                 nrst_i,
  input  wire logic                 ce_i,
  input  wire logic [POF_SEL_W-1:0] output_coding_selector_i,
  input  wire logic                 pix_valid_i,
  input  wire pof_pix_s             pix_i,
  output logic                      pix_ready_o,
  output logic                      byte_valid_o,
  output pof_byte_s                 byte_o,
  output logic                      coding_err_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [POF_CHAN_W-1:0] luma;
  logic                  y_valid;
  logic                  y_sof;
  logic                  next_y_valid;
  logic                  next_y_sof;

  pof_luma #(
    .CHAN_W (POF_CHAN_W)
  ) u_luma (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .r_i    (pix_i.r),
    .g_i    (pix_i.g),
    .b_i    (pix_i.b),
    .y_o    (luma)
  );

  ////////////////////////////////////////////////////////////////////////////
  pof_state_e            state;
  pof_state_e            next_state;
  logic [POF_PIX_W-1:0]  even_pix;
  logic [POF_PIX_W-1:0]  next_even_pix;
  logic [POF_BYTE_W-1:0] hold_byte;
  logic [POF_BYTE_W-1:0] next_hold_byte;
  logic                  pair_odd;
  logic                  next_pair_odd;
  logic                  ready;
  logic                  next_ready;
  logic                  out_valid;
  logic                  next_out_valid;
  pof_byte_s             out_byte;
  pof_byte_s             next_out_byte;
  logic                  err;
  logic                  next_err;
  logic                  take;
  logic                  sel_y8;
  logic                  sel_p12;
  logic                  sel_g16;

  // selector decode and take strobe, shared by every group below
  always_comb begin
    sel_y8   = (output_coding_selector_i == POF_CODE_Y8);
    sel_p12  = (output_coding_selector_i == POF_CODE_P12);
    sel_g16  = (output_coding_selector_i == POF_CODE_G16);
    take     = pix_valid_i && ready;
    // an unknown coding drops pixels rather than emit a malformed stream
    next_err = !(sel_y8 || sel_p12 || sel_g16);
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      err <= 1'b0;
    end else if (ce_i) begin
      err <= next_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the luma stage is one register deep, so the valid and frame-start marks
  // ride one register beside it and meet the luma value at the output
  always_comb begin
    next_y_valid = 1'b0;
    next_y_sof   = y_sof;
    if (state == POF_ST_IDLE && take && sel_y8) begin
      next_y_valid = 1'b1;
      next_y_sof   = pix_i.sof;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      y_valid <= 1'b0;
      y_sof   <= 1'b0;
    end else if (ce_i) begin
      y_valid <= next_y_valid;
      y_sof   <= next_y_sof;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pair phase: leaving the packed coding clears it, so a later switch back
  // never pairs a stale even pixel with a new one
  always_comb begin
    next_pair_odd = pair_odd;
    next_even_pix = even_pix;
    if (state == POF_ST_IDLE) begin
      if (!sel_p12) begin
        next_pair_odd = 1'b0;
      end else if (take) begin
        // a frame start always opens a new pair
        if (!pair_odd || pix_i.sof) begin
          next_pair_odd = 1'b1;
          next_even_pix = pix_i.grey;
        end else begin
          next_pair_odd = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pair_odd <= 1'b0;
      even_pix <= '0;
    end else if (ce_i) begin
      pair_odd <= next_pair_odd;
      even_pix <= next_even_pix;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte sequencer: one byte per cycle, stalling intake for a trailing byte
  always_comb begin
    next_state     = state;
    next_hold_byte = hold_byte;
    next_out_valid = 1'b0;
    next_out_byte  = out_byte;
    next_ready     = ready;

    // luma path has one cycle of latency; the byte leaves right behind it
    if (y_valid) begin
      next_out_valid     = 1'b1;
      next_out_byte.sof  = y_sof;
      next_out_byte.data = luma;
    end

    case (state)
      POF_ST_IDLE: begin
        // an eight-bit grey pixel leaves through the luma group instead
        if (take && sel_p12) begin
          // a frame start always opens a new pair
          if (!pair_odd || pix_i.sof) begin
            next_out_valid     = 1'b1;
            next_out_byte.sof  = pix_i.sof;
            next_out_byte.data = pix_i.grey[POF_HI_MSB:POF_HI_LSB];
          end else begin
            next_out_valid     = 1'b1;
            next_out_byte.sof  = 1'b0;
            next_out_byte.data = {pix_i.grey[POF_LO_MSB:0], even_pix[POF_LO_MSB:0]};
            next_hold_byte     = pix_i.grey[POF_HI_MSB:POF_HI_LSB];
            next_ready         = 1'b0;
            next_state         = POF_ST_B2;
          end
        end else if (take && sel_g16) begin
          next_out_valid     = 1'b1;
          next_out_byte.sof  = pix_i.sof;
          next_out_byte.data = pix_i.grey[POF_BYTE_W-1:0];
          next_hold_byte     = {POF_PAD_ZERO, pix_i.grey[POF_PIX_W-1:POF_BYTE_W]};
          next_ready         = 1'b0;
          next_state         = POF_ST_B1;
        end
      end
      POF_ST_B1, POF_ST_B2: begin
        // second byte of a padded pixel or third byte of a packed pair
        next_out_valid     = 1'b1;
        next_out_byte.sof  = 1'b0;
        next_out_byte.data = hold_byte;
        next_ready         = 1'b1;
        next_state         = POF_ST_IDLE;
      end
      default: begin
        next_state = POF_ST_IDLE;
        next_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state     <= POF_ST_IDLE;
      hold_byte <= POF_BYTE_RST;
      ready     <= 1'b1;
      out_valid <= 1'b0;
      out_byte  <= '0;
    end else if (ce_i) begin
      state     <= next_state;
      hold_byte <= next_hold_byte;
      ready     <= next_ready;
      out_valid <= next_out_valid;
      out_byte  <= next_out_byte;
    end
  end

  assign pix_ready_o  = ready;
  assign byte_valid_o = out_valid;
  assign byte_o       = out_byte;
  assign coding_err_o = err;
endmodule
`default_nettype wire

// ==== verification/pof_formatter_checker.sv ====
/* port checker for the pixel output formatter.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module pof_formatter_checker
  import pof_pkg::*;
(
  input wire logic                 mclk_i,
  input wire logic                 nrst_i,
  input wire logic                 ce_i,
  input wire logic [POF_SEL_W-1:0] output_coding_selector_i,
  input wire logic                 pix_valid_i,
  input wire pof_pix_s             pix_i,
  input wire logic                 pix_ready_o,
  input wire logic                 byte_valid_o,
  input wire pof_byte_s            byte_o,
  input wire logic                 coding_err_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  logic        tk;
  logic        bad;
  logic [15:0] y;
  logic [7:0]  sel;
  assign sel = output_coding_selector_i;
  assign tk  = ce_i && pix_valid_i && pix_ready_o;
  assign bad = !(sel inside {POF_CODE_Y8, POF_CODE_P12, POF_CODE_G16});
  assign y   = 16'(POF_KR) * pix_i.r + 16'(POF_KG) * pix_i.g + 16'(POF_KB) * pix_i.b;
  //////////////////////////////////////////////////////////////////////
  property p_y8; tk && sel == POF_CODE_Y8 ##1 ce_i |=> byte_valid_o && byte_o.data == $past(y[15:8], 2); endproperty
  a_y8: assert property (p_y8) else $error("luma byte wrong");
  property p_p12_first; tk && sel == POF_CODE_P12 && pix_i.sof |=> byte_valid_o && byte_o.sof
    && byte_o.data == $past(pix_i.grey[11:4]); endproperty
  a_p12_first: assert property (p_p12_first) else $error("first packed byte wrong");
  property p_p12_pair; tk && sel == POF_CODE_P12 && pix_i.sof ##1 tk && !pix_i.sof ##1 ce_i
    |-> byte_valid_o && byte_o.data == {$past(pix_i.grey[3:0]), $past(pix_i.grey[3:0], 2)}
    ##1 byte_valid_o && byte_o.data == $past(pix_i.grey[11:4], 2); endproperty
  a_p12_pair: assert property (p_p12_pair) else $error("packed pair bytes wrong");
  property p_g16_lo; tk && sel == POF_CODE_G16 |=> byte_valid_o && byte_o.data == $past(pix_i.grey[7:0]); endproperty
  a_g16_lo: assert property (p_g16_lo) else $error("padded low byte wrong");
  property p_g16_hi; tk && sel == POF_CODE_G16 ##1 ce_i |=> byte_valid_o
    && byte_o.data == {POF_PAD_ZERO, $past(pix_i.grey[11:8], 2)}; endproperty
  a_g16_hi: assert property (p_g16_hi) else $error("padded high byte wrong");
  property p_g16_rdy; tk && sel == POF_CODE_G16 |=> !pix_ready_o; endproperty
  a_g16_rdy: assert property (p_g16_rdy) else $error("padded pixel not stalled");
  property p_err; $past(nrst_i) && $past(ce_i) |-> coding_err_o == $past(bad); endproperty
  a_err: assert property (p_err) else $error("coding error flag wrong");
  property p_drop; tk && bad && !$past(tk) |=> !byte_valid_o; endproperty
  a_drop: assert property (p_drop) else $error("byte from unknown coding");
endmodule
bind pof_formatter pof_formatter_checker pof_formatter_checker_inst (.mclk_i, .nrst_i, .ce_i,
  .output_coding_selector_i, .pix_valid_i, .pix_i, .pix_ready_o, .byte_valid_o, .byte_o, .coding_err_o);
`default_nettype wire

// ==== verification/pof_host_model.sv ====
/* host buffer model: keeps the bytes of the current frame.
   assumes bytes count only with byte_valid_i on enabled cycles. */
`timescale 1ns/1ps
`default_nettype none
module pof_host_model
  import pof_pkg::*;
(
  input wire logic      mclk_i,
  input wire logic      ce_i,
  input wire logic      byte_valid_i,
  input wire pof_byte_s byte_i
);
  logic [7:0] q[$];
  // a frame start opens a fresh buffer; a byte frozen by a low enable counts once
  always @(posedge mclk_i) begin
    if (ce_i && byte_valid_i && byte_i.sof) begin
      q = {byte_i.data};
    end else if (ce_i && byte_valid_i) begin
      q.push_back(byte_i.data);
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_pof_formatter.sv ====
/* testbench for the pixel output formatter.
   assumes the host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_pof_formatter import pof_pkg::*;;
  logic      mclk_i, nrst_i, ce_i, pix_valid_i, pix_ready_o, byte_valid_o, coding_err_o;
  logic[7:0] sel;
  pof_pix_s  pix_i;
  pof_byte_s byte_o;
  int        err_count, tests_run;
  // the host takes a byte only on enabled cycles, like the real sink
  pof_formatter pof_formatter_inst (.mclk_i, .nrst_i, .ce_i, .output_coding_selector_i(sel),
    .pix_valid_i, .pix_i, .pix_ready_o, .byte_valid_o, .byte_o, .coding_err_o);
  pof_host_model pof_host_model_inst (.mclk_i, .ce_i, .byte_valid_i(byte_valid_o), .byte_i(byte_o));
  //////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic px(input logic s, input logic [7:0] r, g, b, input logic [11:0] gr);
    int n = 0;
    while (pix_ready_o !== 1'h1) begin
      pix_valid_i = 1'h0;
      @(negedge mclk_i);
      n++;
      if (n > 9) begin
        err_count++;
        conclude();
      end
    end
    pix_valid_i = 1'h1;
    pix_i = '{s, r, g, b, gr};
    @(negedge mclk_i);
  endtask
  task automatic ex(input logic [7:0] e[$]);
    pix_valid_i = 1'h0;
    repeat (4) @(negedge mclk_i);
    chk(16'(pof_host_model_inst.q.size()), 16'(e.size()));
    foreach (e[i]) chk({8'h00, pof_host_model_inst.q[i]}, {8'h00, e[i]});
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_y8;
    sel = POF_CODE_Y8;
    px(1'h1, 8'h00, 8'h00, 8'h00, 12'hfff);
    px(1'h0, 8'hff, 8'hff, 8'hff, 12'h000);
    px(1'h0, 8'h10, 8'h20, 8'h30, 12'hfff);
    ex({8'h00, 8'hff, 8'h1d});
  endtask
  task automatic t_p12;
    sel = POF_CODE_P12;
    px(1'h1, 8'h00, 8'h00, 8'h00, 12'habc);
    px(1'h0, 8'h00, 8'h00, 8'h00, 12'h123);
    px(1'h0, 8'h00, 8'h00, 8'h00, 12'hfff);
    ex({8'hab, 8'h3c, 8'h12, 8'hff});
    px(1'h1, 8'h00, 8'h00, 8'h00, 12'h000);
    px(1'h0, 8'h00, 8'h00, 8'h00, 12'h5a5);
    ex({8'h00, 8'h50, 8'h5a});
  endtask
  task automatic t_g16;
    sel = POF_CODE_G16;
    px(1'h1, 8'h00, 8'h00, 8'h00, 12'hfff);
    px(1'h0, 8'h00, 8'h00, 8'h00, 12'h0a5);
    ex({8'hff, 8'h0f, 8'ha5, 8'h00});
  endtask
  task automatic t_bad;
    sel = 8'h87;
    px(1'h1, 8'h00, 8'h00, 8'h00, 12'h321);
    ex({8'hff, 8'h0f, 8'ha5, 8'h00});
    chk(16'(coding_err_o), 16'h0001);
  endtask
  task automatic t_ce;
    sel = POF_CODE_P12;
    px(1'h1, 8'h00, 8'h00, 8'h00, 12'h9c3);
    px(1'h0, 8'h00, 8'h00, 8'h00, 12'h4e7);
    // freeze while the trailing byte is owed: nothing may move or repeat
    ce_i = 1'h0;
    repeat (3) @(negedge mclk_i);
    chk(16'(pix_ready_o), 16'h0000);
    ce_i = 1'h1;
    ex({8'h9c, 8'h73, 8'h4e});
  endtask
  task automatic t_rst;
    sel = POF_CODE_G16;
    px(1'h1, 8'h00, 8'h00, 8'h00, 12'h111);
    // reset lands while the high byte is still owed
    pix_valid_i = 1'h0;
    sel = 8'h87;
    nrst_i = 1'h0;
    @(negedge mclk_i);
    chk({13'h0000, pix_ready_o, byte_valid_o, coding_err_o}, 16'h0004);
    nrst_i = 1'h1;
    sel = POF_CODE_G16;
    px(1'h1, 8'h00, 8'h00, 8'h00, 12'h6b2);
    ex({8'hb2, 8'h06});
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    mclk_i = 1'h0;
    forever #5 mclk_i = ~mclk_i;
  end
  initial begin
    nrst_i = 1'h0;
    ce_i = 1'h1;
    pix_valid_i = 1'h0;
    pix_i = '0;
    sel = POF_CODE_Y8;
    err_count = 0;
    tests_run = 0;
    repeat (16) @(negedge mclk_i);
    nrst_i = 1'h1;
    t_y8();
    t_p12();
    t_g16();
    t_bad();
    t_ce();
    t_rst();
    conclude();
  end
endmodule
`default_nettype wire
